// ---- pdr_consts.svh ----
/*
  Offsets, field positions, reset values and figures of the phase detector
  range configuration registers. Assumes inclusion by bare name.
*/
`ifndef PDR_CONSTS_SVH
`define PDR_CONSTS_SVH

`define PDR_ADDR_COARSE      8'h74
`define PDR_ADDR_MONITOR     8'h76
`define PDR_RST_COARSE       8'h85
`define PDR_RST_MONITOR      8'h06
`define PDR_MASK_COARSE      8'hef
`define PDR_MASK_MONITOR     8'hbf
`define PDR_BIT_LOSS_EN      7
`define PDR_BIT_WIDE_EN      6
`define PDR_BIT_EXT_RESP     5
`define PDR_BIT_NOISE_WIN    7
`define PDR_BIT_MON_EN       5
`define PDR_BIT_MON_BO_EN    4
`define PDR_RANGE_MSB        3
`define PDR_CODE_MAX         4'hc
`define PDR_WINDOW_PERCENT   5
`define PDR_WINDOW_DIV       (100 / `PDR_WINDOW_PERCENT)

`endif

// ---- pdr_pkg.sv ----
/*
  Types shared by the phase detector range configuration block.
  Assumes pdr_consts.svh is available for the constants.
*/
package pdr_pkg;

  typedef logic [13:0] pdr_ui_t;

  // Microprocessor port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pdr_req_s;

  typedef enum logic [1:0] {
    PDR_WIN_UNSYNCED,
    PDR_WIN_TRACKING
  } pdr_win_e;

  // All state of the top module
  typedef struct packed {
    logic [7:0]  coarse;
    logic [7:0]  monitor;
    logic [7:0]  rdata;
    pdr_ui_t     range_ui;
    pdr_ui_t     det_limit_ui;
    pdr_ui_t     loss_limit_ui;
    logic        edge_accept;
    logic        edge_reject;
    logic [23:0] since_edge;
    pdr_win_e    win;
  } pdr_state_s;

endpackage : pdr_pkg

// ---- pdr_range_decode.sv ----
/*
  Decodes the four-bit coarse range code into a span in unit intervals.
  Purely combinational; the instantiating module registers the result.
*/
`timescale 1ns/10ps
`include "pdr_consts.svh"

module pdr_range_decode (
  input  wire logic [3:0]      i_code,
  output pdr_pkg::pdr_ui_t     o_span_ui
);

  logic [3:0] clamped;

  always_comb begin
    // Codes 1100 to 1111 all give the widest span
    clamped = (i_code > `PDR_CODE_MAX) ? `PDR_CODE_MAX : i_code;
    // Span doubles per code: 2^(code+1) - 1
    o_span_ui = 14'((15'h0002 << clamped) - 15'h0001);
  end

endmodule : pdr_range_decode

// ---- pdr_range_config.sv ----
/*
  Coarse phase range and low-rate noise window configuration for the
  output-timing PLL phase detector, reached through the microprocessor
  port. Holds the two configuration registers, the decoded range spans
  handed to the coarse detector and loss detector, and the edge filter
  that applies the noise window to low-rate references.
  Assumes a single 25 MHz clock, synchronous active-low reset and inputs
  synchronous to that clock. Assumes the microprocessor port strobes
  each read and write for one cycle, and that I_EXPECTED_PERIOD is given
  in clock cycles and is held steady while the window is in use.
*/
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`include "pdr_consts.svh"

module pdr_range_config (
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic        I_EDGE,
  input  wire logic        I_LOW_RATE,
  input  wire logic [23:0] I_EXPECTED_PERIOD,
  output logic      [7:0]  O_RDATA,
  output logic      [13:0] O_COARSE_RANGE_UI,
  output logic      [13:0] O_DETECTOR_LIMIT_UI,
  output logic      [13:0] O_PHASE_LOSS_LIMIT_UI,
  output logic             O_WIDE_RANGE_ENABLE,
  output logic             O_PHASE_LOSS_ENABLE,
  output logic             O_EXTENDED_PHASE_RESPONSE,
  output logic             O_EDGE_NOISE_WINDOW_ENABLE,
  output logic             O_MONITOR_ENABLE,
  output logic             O_MONITOR_BUILDOUT_ENABLE,
  output logic      [3:0]  O_MONITOR_LIMIT,
  output logic             O_EDGE_ACCEPT,
  output logic             O_EDGE_REJECT
);

  pdr_pkg::pdr_state_s state;
  pdr_pkg::pdr_state_s next_state;
  pdr_pkg::pdr_req_s   req;
  pdr_pkg::pdr_ui_t    span_ui;
  logic [23:0]         tolerance;
  logic [23:0]         win_lo;
  logic [23:0]         win_hi;
  logic                in_window;
  logic                windowing;
  logic [24:0]         win_sum;
  logic                edge_due;
  logic [23:0]         since_inc;

  //////////////////////////////////////////////////////////////////////////////
  // Microprocessor port request

  always_comb begin
    req.addr  = I_ADDR;
    req.wdata = I_WDATA;
    req.wr    = I_WR;
    req.rd    = I_RD;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Range decode

  pdr_range_decode i_pdr_range_decode (
    .i_code    (state.coarse[`PDR_RANGE_MSB:0]),
    .o_span_ui (span_ui)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Noise window arithmetic

  always_comb begin
    tolerance = I_EXPECTED_PERIOD / 24'(`PDR_WINDOW_DIV);
    win_lo    = I_EXPECTED_PERIOD - tolerance;
    win_sum   = {1'b0, I_EXPECTED_PERIOD} + {1'b0, tolerance};
    // Clamp so a long period cannot wrap the upper bound to a small value
    win_hi    = win_sum[24] ? 24'hffffff : win_sum[23:0];
    in_window = (state.since_edge >= win_lo) &&
                (state.since_edge <= win_hi);
    edge_due  = (state.since_edge > win_hi);
    windowing = state.monitor[`PDR_BIT_NOISE_WIN] && I_LOW_RATE;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Edge spacing counter

  always_comb begin
    // Saturate so a lost reference cannot wrap back into the window
    if (state.since_edge == 24'hffffff) begin
      since_inc = state.since_edge;
    end else begin
      since_inc = state.since_edge + 24'h000001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_state             = state;
    next_state.edge_accept = 1'b0;
    next_state.edge_reject = 1'b0;

    // Register writes
    if (req.wr) begin
      case (req.addr)
        `PDR_ADDR_COARSE: begin
          next_state.coarse = req.wdata & `PDR_MASK_COARSE;
        end
        `PDR_ADDR_MONITOR: begin
          next_state.monitor = req.wdata & `PDR_MASK_MONITOR;
        end
        default: begin
        end
      endcase
    end

    // Register reads, unmapped addresses read zero
    if (req.rd) begin
      case (req.addr)
        `PDR_ADDR_COARSE: begin
          next_state.rdata = state.coarse;
        end
        `PDR_ADDR_MONITOR: begin
          next_state.rdata = state.monitor;
        end
        default: begin
          next_state.rdata = 8'h00;
        end
      endcase
    end

    // One field limits both detector and loss detector
    next_state.range_ui = span_ui;
    next_state.det_limit_ui = state.coarse[`PDR_BIT_WIDE_EN] ?
                              span_ui : 14'h0000;
    next_state.loss_limit_ui = state.coarse[`PDR_BIT_LOSS_EN] ?
                               span_ui : 14'h0000;

    // Edge window tracking
    next_state.since_edge = since_inc;
    case (state.win)
      pdr_pkg::PDR_WIN_UNSYNCED: begin
        if (I_EDGE) begin
          next_state.edge_accept = 1'b1;
          next_state.since_edge  = 24'h000001;
          next_state.win         = pdr_pkg::PDR_WIN_TRACKING;
        end
      end
      pdr_pkg::PDR_WIN_TRACKING: begin
        if (!windowing) begin
          if (I_EDGE) begin
            next_state.edge_accept = 1'b1;
            next_state.since_edge  = 24'h000001;
          end
        end else if (I_EDGE && in_window) begin
          next_state.edge_accept = 1'b1;
          next_state.since_edge  = 24'h000001;
        end else if (I_EDGE) begin
          next_state.edge_reject = 1'b1;
        end else if (edge_due) begin
          // Expected edge missed: reopen to resynchronise
          next_state.win = pdr_pkg::PDR_WIN_UNSYNCED;
        end
      end
      default: begin
        next_state.win = pdr_pkg::PDR_WIN_UNSYNCED;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state               <= '0;
      state.coarse        <= `PDR_RST_COARSE;
      state.monitor       <= `PDR_RST_MONITOR;
      state.win           <= pdr_pkg::PDR_WIN_UNSYNCED;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register outputs

  always_comb begin
    O_RDATA                    = state.rdata;
    O_WIDE_RANGE_ENABLE        = state.coarse[`PDR_BIT_WIDE_EN];
    O_PHASE_LOSS_ENABLE        = state.coarse[`PDR_BIT_LOSS_EN];
    O_EXTENDED_PHASE_RESPONSE  = state.coarse[`PDR_BIT_EXT_RESP];
    O_EDGE_NOISE_WINDOW_ENABLE = state.monitor[`PDR_BIT_NOISE_WIN];
    O_MONITOR_ENABLE           = state.monitor[`PDR_BIT_MON_EN];
    O_MONITOR_BUILDOUT_ENABLE  = state.monitor[`PDR_BIT_MON_BO_EN];
    O_MONITOR_LIMIT            = state.monitor[3:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Derived range outputs

  always_comb begin
    O_COARSE_RANGE_UI          = state.range_ui;
    O_DETECTOR_LIMIT_UI        = state.det_limit_ui;
    O_PHASE_LOSS_LIMIT_UI      = state.loss_limit_ui;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Edge filter outputs

  always_comb begin
    O_EDGE_ACCEPT              = state.edge_accept;
    O_EDGE_REJECT              = state.edge_reject;
  end

endmodule : pdr_range_config

// ---- pdr_range_config_assertions.sv ----
/* Checker of the range configuration block ports.
   Assumes a bind to pdr_range_config from the testbench top file. */
`timescale 1ns/10ps
module pdr_range_config_assertions (
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_EDGE,
  input  wire logic        I_LOW_RATE,
  input  wire logic [13:0] O_COARSE_RANGE_UI,
  input  wire logic [13:0] O_DETECTOR_LIMIT_UI,
  input  wire logic [13:0] O_PHASE_LOSS_LIMIT_UI,
  input  wire logic        O_WIDE_RANGE_ENABLE,
  input  wire logic        O_PHASE_LOSS_ENABLE,
  input  wire logic        O_EDGE_NOISE_WINDOW_ENABLE,
  input  wire logic        O_EDGE_ACCEPT,
  input  wire logic        O_EDGE_REJECT
);
  function automatic logic [13:0] span(input logic [3:0] c);
    return (c > 4'hb) ? 14'h1fff : 14'((14'h2 << c) - 14'h1);
  endfunction : span
  wire wr74 = I_WR && (I_ADDR == 8'h74);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  //////////////////////////////////////////////////////////////////////////
  range_span_a: assert property (wr74 ##1 !wr74 |=>
    O_COARSE_RANGE_UI == span($past(I_WDATA[3:0], 2))) else $error("span");
  same_limit_a: assert property (O_WIDE_RANGE_ENABLE &&
    O_PHASE_LOSS_ENABLE && $past(O_WIDE_RANGE_ENABLE) &&
    $past(O_PHASE_LOSS_ENABLE) |->
    O_DETECTOR_LIMIT_UI == O_PHASE_LOSS_LIMIT_UI) else $error("limits");
  wide_off_a: assert property (!O_WIDE_RANGE_ENABLE &&
    !$past(O_WIDE_RANGE_ENABLE) |-> O_DETECTOR_LIMIT_UI == 14'h0)
    else $error("wide off");
  loss_off_a: assert property (!O_PHASE_LOSS_ENABLE &&
    !$past(O_PHASE_LOSS_ENABLE) |-> O_PHASE_LOSS_LIMIT_UI == 14'h0)
    else $error("loss off");
  wide_write_a: assert property (wr74 |=>
    O_WIDE_RANGE_ENABLE == $past(I_WDATA[6])) else $error("wide bit");
  reject_cause_a: assert property (O_EDGE_REJECT |-> $past(I_EDGE) &&
    $past(I_LOW_RATE) && $past(O_EDGE_NOISE_WINDOW_ENABLE))
    else $error("reject");
  all_edges_a: assert property (!O_EDGE_NOISE_WINDOW_ENABLE && I_EDGE
    |=> O_EDGE_ACCEPT && !O_EDGE_REJECT) else $error("accept");
  cover property (O_EDGE_REJECT);
  cover property (O_COARSE_RANGE_UI == 14'h1fff);
  cover property (O_WIDE_RANGE_ENABLE && O_PHASE_LOSS_ENABLE);
endmodule : pdr_range_config_assertions

// ---- pdr_range_config_tb.sv ----
/* Self-checking testbench of the range configuration block.
   Assumes design and checker files are compiled before it. */
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module pdr_range_config_tb;
  logic        I_CLK, I_RST_N, I_WR, I_RD, I_EDGE, I_LOW_RATE;
  logic [7:0]  I_ADDR, I_WDATA, rdata;
  logic [23:0] I_EXPECTED_PERIOD;
  logic [13:0] ui, det, loss;
  logic        wide, lossen, acc, rej;
  logic        ext, nwin, mon_en, mon_bo;
  logic [3:0]  mon_lim;
  int          fails = 0, comparisons = 0, cyc = 0;
  pdr_range_config i_pdr_range_config (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .I_EDGE(I_EDGE), .I_LOW_RATE(I_LOW_RATE),
    .I_EXPECTED_PERIOD(I_EXPECTED_PERIOD), .O_RDATA(rdata),
    .O_COARSE_RANGE_UI(ui), .O_DETECTOR_LIMIT_UI(det),
    .O_PHASE_LOSS_LIMIT_UI(loss), .O_WIDE_RANGE_ENABLE(wide),
    .O_PHASE_LOSS_ENABLE(lossen), .O_EXTENDED_PHASE_RESPONSE(ext),
    .O_EDGE_NOISE_WINDOW_ENABLE(nwin), .O_MONITOR_ENABLE(mon_en),
    .O_MONITOR_BUILDOUT_ENABLE(mon_bo), .O_MONITOR_LIMIT(mon_lim),
    .O_EDGE_ACCEPT(acc), .O_EDGE_REJECT(rej));
  initial begin
    I_CLK = 1'b0;
    forever #20 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      results();
    end
  end
  task results;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  //////////////////////////////////////////////////////////////////////////
  task wr(input logic [7:0] a, input logic [7:0] d);
    I_ADDR = a;
    I_WDATA = d;
    I_WR = 1'b1;
    @(negedge I_CLK) I_WR = 1'b0;
    repeat (2) @(negedge I_CLK);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    I_ADDR = a;
    I_RD = 1'b1;
    @(negedge I_CLK) I_RD = 1'b0;
    @(negedge I_CLK);
    `CHK(rdata, e)
  endtask : rd
  task pulse(input int g, input logic e);
    repeat (g - 2) @(negedge I_CLK);
    I_EDGE = 1'b1;
    @(negedge I_CLK);
    `CHK({rej, acc}, {e, ~e})
    I_EDGE = 1'b0;
    @(negedge I_CLK);
  endtask : pulse
  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(8'h74, 8'h85);
    rd(8'h76, 8'h06);
    `CHK(ui, 14'd63)
    `CHK({det, loss}, {14'd0, 14'd63})
    `CHK({ext, nwin, mon_en, mon_bo, mon_lim}, 8'h06)
  endtask : t_reset
  task t_codes;
    logic [13:0] e;
    for (int c = 0; c < 16; c++) begin
      e = (c > 11) ? 14'h1fff : 14'((14'h2 << c) - 14'h1);
      wr(8'h74, 8'hc0 | 8'(c));
      `CHK(ui, e)
      `CHK({det, loss}, {e, e})
    end
    wr(8'h74, 8'h83);
    `CHK({wide, lossen, det, loss}, {2'b01, 14'd0, 14'd15})
    wr(8'h74, 8'h43);
    `CHK({wide, lossen, det, loss}, {2'b10, 14'd15, 14'd0})
  endtask : t_codes
  task t_regs;
    wr(8'h74, 8'hff);
    rd(8'h74, 8'hef);
    wr(8'h76, 8'hff);
    rd(8'h76, 8'hbf);
    `CHK({ext, nwin, mon_en, mon_bo, mon_lim}, 8'hff)
    wr(8'h75, 8'h55);
    rd(8'h75, 8'h00);
  endtask : t_regs
  task t_window;
    wr(8'h76, 8'h80);
    `CHK({nwin, mon_en, mon_bo, mon_lim}, 7'h40)
    I_LOW_RATE = 1'b1;
    I_EXPECTED_PERIOD = 24'd100;
    pulse(5, 1'b0);
    pulse(50, 1'b1);
    pulse(50, 1'b0);
    I_LOW_RATE = 1'b0;
    pulse(30, 1'b0);
    I_LOW_RATE = 1'b1;
    wr(8'h76, 8'h00);
    pulse(30, 1'b0);
  endtask : t_window
  initial begin
    {I_RST_N, I_WR, I_RD, I_EDGE, I_LOW_RATE} = 5'h0;
    {I_ADDR, I_WDATA, I_EXPECTED_PERIOD} = 40'h0;
    repeat (3) @(negedge I_CLK);
    I_RST_N = 1'b1;
    repeat (2) @(negedge I_CLK);
    t_reset();
    t_codes();
    t_regs();
    t_window();
    results();
  end
endmodule : pdr_range_config_tb
bind pdr_range_config pdr_range_config_assertions i_chk (.I_CLK(I_CLK),
  .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_EDGE(I_EDGE), .I_LOW_RATE(I_LOW_RATE),
  .O_COARSE_RANGE_UI(O_COARSE_RANGE_UI),
  .O_DETECTOR_LIMIT_UI(O_DETECTOR_LIMIT_UI),
  .O_PHASE_LOSS_LIMIT_UI(O_PHASE_LOSS_LIMIT_UI),
  .O_WIDE_RANGE_ENABLE(O_WIDE_RANGE_ENABLE),
  .O_PHASE_LOSS_ENABLE(O_PHASE_LOSS_ENABLE),
  .O_EDGE_NOISE_WINDOW_ENABLE(O_EDGE_NOISE_WINDOW_ENABLE),
  .O_EDGE_ACCEPT(O_EDGE_ACCEPT), .O_EDGE_REJECT(O_EDGE_REJECT));
